// [common/pwel_pkg.sv]
/*
  Constants for the posted-write error log: register offsets, field
  positions and reset values.
  Assumes a 12-bit byte address on the register port and 32-bit data.
*/
package pwel_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 12'hf80;
  localparam logic [ADDR_W-1:0] OFS_ADDR_LOG = 12'hf84;
  localparam logic [ADDR_W-1:0] OFS_DATA_LOG = 12'hf88;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'hf8c;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'hf90;

  // ----------------------------------------------------------------
  // Field layout of the control and status register
  // ----------------------------------------------------------------
  localparam int EN_BIT = 31;
  localparam int STATUS_BIT = 24;
  localparam int TC_LSB = 4;
  localparam int TC_W = 4;
  localparam int SIZ_LSB = 0;
  localparam int SIZ_W = 2;

  // ----------------------------------------------------------------
  // Interrupt status and mask layout
  // ----------------------------------------------------------------
  localparam int INT_W = 2;
  localparam int INT_CAPTURED = 0;
  localparam int INT_MISSED = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [TC_W-1:0] RST_TC = 4'h0;
  localparam logic [SIZ_W-1:0] RST_SIZ = 2'h0;
  localparam logic [INT_W-1:0] RST_INT = 2'h0;

endpackage

// [common/pwel_log_if.sv]
/*
  Interface between the register front end and the capture unit.
  Assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ps
interface pwel_log_if;
  logic log_en;
  logic clear_status;
  logic err_event;
  logic [pwel_pkg::TC_W-1:0] evt_tc;
  logic [pwel_pkg::SIZ_W-1:0] evt_size;
  logic [pwel_pkg::DATA_W-1:0] evt_addr;
  logic [pwel_pkg::DATA_W-1:0] evt_data;
  logic error_status;
  logic captured;
  logic missed;
  logic [pwel_pkg::TC_W-1:0] transaction_code_log;
  logic [pwel_pkg::SIZ_W-1:0] size_code_log;
  logic [pwel_pkg::DATA_W-1:0] captured_address;
  logic [pwel_pkg::DATA_W-1:0] captured_data;

  // ----------------------------------------------------------------
  // Ends
  // ----------------------------------------------------------------
  modport ctl (
    output log_en, clear_status, err_event, evt_tc, evt_size, evt_addr, evt_data,
    input error_status, captured, missed, transaction_code_log, size_code_log,
    input captured_address, captured_data
  );
  modport cap (
    input log_en, clear_status, err_event, evt_tc, evt_size, evt_addr, evt_data,
    output error_status, captured, missed, transaction_code_log, size_code_log,
    output captured_address, captured_data
  );
endinterface

// [logic/pwel_capture.sv]
/*
  Capture unit: holds the error record and the error status flag.
  Assumes err_event is a one-cycle pulse per failed posted write.
*/
`timescale 1ns/1ps
module pwel_capture (
  input wire logic ref_clk,
  input wire logic rst_n,
  pwel_log_if.cap lg
);

  logic error_status;
  logic next_error_status;
  logic [pwel_pkg::TC_W-1:0] tc;
  logic [pwel_pkg::TC_W-1:0] next_tc;
  logic [pwel_pkg::SIZ_W-1:0] siz;
  logic [pwel_pkg::SIZ_W-1:0] next_siz;
  logic [pwel_pkg::DATA_W-1:0] addr;
  logic [pwel_pkg::DATA_W-1:0] next_addr;
  logic [pwel_pkg::DATA_W-1:0] data;
  logic [pwel_pkg::DATA_W-1:0] next_data;
  logic take;

  // ----------------------------------------------------------------
  // Record capture
  // ----------------------------------------------------------------
  // A clear in the same cycle frees the slot, so the new error wins
  assign take = lg.err_event && lg.log_en && (!error_status || lg.clear_status);

  // Next record and flag
  always_comb
  begin
    next_error_status = error_status;
    next_tc = tc;
    next_siz = siz;
    next_addr = addr;
    next_data = data;
    if (take)
    begin
      next_error_status = 1'b1;
      next_tc = lg.evt_tc;
      next_siz = lg.evt_size;
      next_addr = lg.evt_addr;
      next_data = lg.evt_data;
    end
    else if (lg.clear_status)
    begin
      next_error_status = 1'b0;
    end
  end

  // Record registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      error_status <= 1'b0;
      tc <= pwel_pkg::RST_TC;
      siz <= pwel_pkg::RST_SIZ;
      addr <= pwel_pkg::RST_WORD;
      data <= pwel_pkg::RST_WORD;
    end
    else
    begin
      error_status <= next_error_status;
      tc <= next_tc;
      siz <= next_siz;
      addr <= next_addr;
      data <= next_data;
    end
  end

  assign lg.error_status = error_status;
  assign lg.captured = take;
  assign lg.missed = lg.err_event && lg.log_en && error_status && !lg.clear_status;
  assign lg.transaction_code_log = tc;
  assign lg.size_code_log = siz;
  assign lg.captured_address = addr;
  assign lg.captured_data = data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_capture_sets_record: assert property (
    (lg.err_event && lg.log_en && !error_status)
      |=> (error_status && addr == $past(lg.evt_addr) && data == $past(lg.evt_data)))
    else $error("Bus error with logging on was not captured");
  a_record_held: assert property (
    (error_status && !lg.clear_status)
      |=> (error_status && $stable(addr) && $stable(data) && $stable(tc) && $stable(siz)))
    else $error("Held error record changed before clear");
  a_clear_drops_status: assert property (
    (lg.clear_status && !(lg.err_event && lg.log_en)) |=> !error_status)
    else $error("Status not cleared by write of one");
  a_disabled_ignores: assert property (
    (lg.err_event && !lg.log_en && !error_status) |=> !error_status)
    else $error("Error captured while logging disabled");

endmodule

// [logic/pwel_top.sv]
/*
  Posted-write error log: register front end, interrupt logic and the
  capture unit.
  Assumes a single-cycle register port with read data one cycle after
  the read strobe, and a bus master that reports each drained posted
  write with a one-cycle completion pulse and its bus-error outcome.
  Assumes software never raises both strobes together and reads the
  data log only while the status bit is set.
  The interrupt line is a level; whoever routes it onward owns any
  synchronising or pin steering.
*/
`timescale 1ns/1ps
module pwel_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [pwel_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pwel_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pwel_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pw_done,
  input wire logic pw_berr,
  input wire logic [pwel_pkg::TC_W-1:0] pw_tc,
  input wire logic [pwel_pkg::SIZ_W-1:0] pw_size,
  input wire logic [pwel_pkg::DATA_W-1:0] pw_addr,
  input wire logic [pwel_pkg::DATA_W-1:0] pw_data,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pwel_log_if lg ();

  logic log_en;
  logic next_log_en;
  logic [pwel_pkg::INT_W-1:0] int_status;
  logic [pwel_pkg::INT_W-1:0] next_int_status;
  logic [pwel_pkg::INT_W-1:0] int_mask;
  logic [pwel_pkg::INT_W-1:0] next_int_mask;
  logic [pwel_pkg::DATA_W-1:0] next_rdata;
  logic [pwel_pkg::INT_W-1:0] int_events;
  logic wr_ctrl;
  logic wr_int_status;
  logic wr_int_mask;
  logic error_status;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Writes to any other offset are dropped without effect
  assign wr_ctrl = reg_wr && (reg_addr == pwel_pkg::OFS_CTRL_STATUS);
  assign wr_int_status = reg_wr && (reg_addr == pwel_pkg::OFS_INT_STATUS);
  assign wr_int_mask = reg_wr && (reg_addr == pwel_pkg::OFS_INT_MASK);
  // Status flag lives in the capture unit beside the record it guards
  assign error_status = lg.error_status;

  // ----------------------------------------------------------------
  // Capture unit hookup
  // ----------------------------------------------------------------
  // Only a drained posted write that ends in a bus error counts
  assign lg.err_event = pw_done && pw_berr;
  assign lg.evt_tc = pw_tc;
  assign lg.evt_size = pw_size;
  assign lg.evt_addr = pw_addr;
  assign lg.evt_data = pw_data;
  assign lg.log_en = log_en;
  // Writing 1 clears the flag; a written 0 leaves it alone
  assign lg.clear_status = wr_ctrl && reg_wdata[pwel_pkg::STATUS_BIT];

  pwel_capture u_capture (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .lg(lg.cap)
  );

  // ----------------------------------------------------------------
  // Logging enable
  // ----------------------------------------------------------------
  // The enable takes the written value; a combined clear-and-disable
  // write therefore ends with both bits low in the same cycle unless a bus error arrives with it
  always_comb
  begin
    next_log_en = log_en;
    if (wr_ctrl)
    begin
      next_log_en = reg_wdata[pwel_pkg::EN_BIT];
    end
  end

  // Enable register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      log_en <= 1'b0;
    end
    else
    begin
      log_en <= next_log_en;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Captured record and error dropped while a record was held
  // Mask bits only gate the output; status still records every event
  assign int_events[pwel_pkg::INT_CAPTURED] = lg.captured;
  assign int_events[pwel_pkg::INT_MISSED] = lg.missed;

  // Set wins over a write-one clear in the same cycle
  always_comb
  begin
    next_int_status = int_status;
    next_int_mask = int_mask;
    if (wr_int_status)
    begin
      next_int_status = int_status & ~reg_wdata[pwel_pkg::INT_W-1:0];
    end
    next_int_status = next_int_status | int_events;
    if (wr_int_mask)
    begin
      next_int_mask = reg_wdata[pwel_pkg::INT_W-1:0];
    end
  end

  // Interrupt registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_status <= pwel_pkg::RST_INT;
      int_mask <= pwel_pkg::RST_INT;
    end
    else
    begin
      int_status <= next_int_status;
      int_mask <= next_int_mask;
    end
  end

  // Level output; nothing leaves the block while logging is off
  assign irq = log_en && (|(int_status & int_mask));

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Code fields and address log are masked by the status flag; the data
  // log is not, so its stale word stays readable after a clear
  always_comb
  begin
    next_rdata = pwel_pkg::RST_WORD;
    if (reg_rd)
    begin
      case (reg_addr)
        pwel_pkg::OFS_CTRL_STATUS:
        begin
          next_rdata[pwel_pkg::EN_BIT] = log_en;
          next_rdata[pwel_pkg::STATUS_BIT] = error_status;
          if (error_status)
          begin
            next_rdata[pwel_pkg::TC_LSB +: pwel_pkg::TC_W] = lg.transaction_code_log;
            next_rdata[pwel_pkg::SIZ_LSB +: pwel_pkg::SIZ_W] = lg.size_code_log;
          end
        end
        pwel_pkg::OFS_ADDR_LOG:
        begin
          // Gated like the code fields, so a cleared record reads as zero
          if (error_status)
          begin
            next_rdata = lg.captured_address;
          end
        end
        pwel_pkg::OFS_DATA_LOG:
        begin
          // Returned unqualified; software reads it only with status set
          next_rdata = lg.captured_data;
        end
        pwel_pkg::OFS_INT_STATUS:
        begin
          // Upper bits read as zero
          next_rdata[pwel_pkg::INT_W-1:0] = int_status;
        end
        pwel_pkg::OFS_INT_MASK:
        begin
          next_rdata[pwel_pkg::INT_W-1:0] = int_mask;
        end
        default:
        begin
          next_rdata = pwel_pkg::RST_WORD;
        end
      endcase
    end
  end

  // Read data register: valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= pwel_pkg::RST_WORD;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Checks watch registers and decoded strobes rather than the bench's
  // own drive, so a bench slip cannot mask a broken block
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Interrupt path and register writes
  a_irq_follows_capture: assert property (
    (lg.captured && log_en && int_mask[pwel_pkg::INT_CAPTURED] && !wr_ctrl && !wr_int_mask) |=> irq)
    else $error("Captured record with open mask did not raise the interrupt");

  a_enable_gates_irq: assert property (
    !log_en |-> !irq)
    else $error("Interrupt raised while logging is off");

  a_capture_sets_int: assert property (
    lg.captured |=> int_status[pwel_pkg::INT_CAPTURED])
    else $error("Capture did not set its interrupt status bit");

  a_miss_sets_int: assert property (
    lg.missed |=> int_status[pwel_pkg::INT_MISSED])
    else $error("Refused error did not set its interrupt status bit");

  a_int_clear_ones: assert property (
    (wr_int_status && reg_wdata[pwel_pkg::INT_CAPTURED] && !lg.captured)
      |=> !int_status[pwel_pkg::INT_CAPTURED])
    else $error("Interrupt status bit not cleared by write of one");

  a_mask_follows_write: assert property (
    wr_int_mask |=> (int_mask == $past(reg_wdata[pwel_pkg::INT_W-1:0])))
    else $error("Mask register did not take written value");

  a_enable_follows_write: assert property (
    wr_ctrl |=> (log_en == $past(reg_wdata[pwel_pkg::EN_BIT])))
    else $error("Enable bit did not take written value");

  a_combined_disable: assert property (
    (wr_ctrl && reg_wdata[pwel_pkg::STATUS_BIT] && !reg_wdata[pwel_pkg::EN_BIT] && !lg.err_event)
      |=> (!log_en && !error_status))
    else $error("Combined clear and disable write not accepted");

  a_zero_write_keeps_status: assert property (
    (wr_ctrl && !reg_wdata[pwel_pkg::STATUS_BIT] && error_status) |=> error_status)
    else $error("Writing zero changed the status bit");

  // Read path and interrupt status hold
  a_status_readback: assert property (
    (reg_rd && reg_addr == pwel_pkg::OFS_CTRL_STATUS)
      |=> (reg_rdata[pwel_pkg::EN_BIT] == $past(log_en)
           && reg_rdata[pwel_pkg::STATUS_BIT] == $past(error_status)))
    else $error("Enable or status bit read back wrong");

  a_addr_read_gated: assert property (
    (reg_rd && reg_addr == pwel_pkg::OFS_ADDR_LOG && !error_status) |=> (reg_rdata == pwel_pkg::RST_WORD))
    else $error("Address log read nonzero with status clear");

  a_codes_read_gated: assert property (
    (reg_rd && reg_addr == pwel_pkg::OFS_CTRL_STATUS && !error_status)
      |=> (reg_rdata[pwel_pkg::TC_LSB +: pwel_pkg::TC_W] == pwel_pkg::RST_TC
           && reg_rdata[pwel_pkg::SIZ_LSB +: pwel_pkg::SIZ_W] == pwel_pkg::RST_SIZ))
    else $error("Code fields read nonzero with status clear");

  a_data_readback: assert property (
    (reg_rd && reg_addr == pwel_pkg::OFS_DATA_LOG) |=> (reg_rdata == $past(lg.captured_data)))
    else $error("Data log read did not return the held word");

  a_capture_readback: assert property (
    (lg.err_event && log_en && !error_status && !reg_wr) ##1 (reg_rd && reg_addr == pwel_pkg::OFS_ADDR_LOG)
      |=> (reg_rdata == $past(pw_addr, 2)))
    else $error("Captured address not returned on read");

  a_size_readback: assert property (
    (lg.err_event && log_en && !error_status && !reg_wr) ##1 (reg_rd && reg_addr == pwel_pkg::OFS_CTRL_STATUS)
      |=> (reg_rdata[pwel_pkg::SIZ_LSB +: pwel_pkg::SIZ_W] == $past(pw_size, 2)))
    else $error("Captured size code not returned on read");

  a_unmapped_read_zero: assert property (
    (reg_rd && reg_addr != pwel_pkg::OFS_CTRL_STATUS && reg_addr != pwel_pkg::OFS_ADDR_LOG
      && reg_addr != pwel_pkg::OFS_DATA_LOG && reg_addr != pwel_pkg::OFS_INT_STATUS
      && reg_addr != pwel_pkg::OFS_INT_MASK) |=> (reg_rdata == pwel_pkg::RST_WORD))
    else $error("Unmapped read returned nonzero data");

  a_rdata_idle_zero: assert property (
    !reg_rd |=> (reg_rdata == pwel_pkg::RST_WORD))
    else $error("Read data not zero outside a read");

  a_int_sticky: assert property (
    (int_status[pwel_pkg::INT_CAPTURED] && !wr_int_status) |=> int_status[pwel_pkg::INT_CAPTURED])
    else $error("Interrupt status bit lost without clear");

  // Capture status
  a_status_rise_cause: assert property (
    $rose(error_status) |-> $past(lg.captured))
    else $error("Status bit rose without a captured bus error");

endmodule

// [tb/pwel_bus_slave.sv]
/*
  Behavioural model of the processor-bus slave that ends posted writes
  drained from the posted_write_fifo, cleanly or with a bus error.
  Assumes the bench calls finish_write from its own thread, one call at a
  time, on the block's clock.
*/
`timescale 1ns/1ps
module pwel_bus_slave (
  input wire logic ref_clk,
  output logic pw_done,
  output logic pw_berr,
  output logic [pwel_pkg::TC_W-1:0] pw_tc,
  output logic [pwel_pkg::SIZ_W-1:0] pw_size,
  output logic [pwel_pkg::DATA_W-1:0] pw_addr,
  output logic [pwel_pkg::DATA_W-1:0] pw_data
);
  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  // Quiet bus at time zero
  initial
  begin
    pw_done = 1'b0;
    pw_berr = 1'b0;
    pw_tc = '0;
    pw_size = '0;
    pw_addr = '0;
    pw_data = '0;
  end

  // ----------------------------------------------------------------
  // One write termination
  // ----------------------------------------------------------------
  // Outcome stands for exactly one cycle; afterwards the qualifiers show
  // the inverse, so a design that samples them late picks up garbage
  task automatic finish_write(
    input logic berr,
    input logic [pwel_pkg::TC_W-1:0] tc,
    input logic [pwel_pkg::SIZ_W-1:0] size,
    input logic [pwel_pkg::DATA_W-1:0] addr,
    input logic [pwel_pkg::DATA_W-1:0] data
  );
    @(posedge ref_clk);
    pw_done <= 1'b1;
    pw_berr <= berr;
    pw_tc <= tc;
    pw_size <= size;
    pw_addr <= addr;
    pw_data <= data;
    @(posedge ref_clk);
    pw_done <= 1'b0;
    pw_berr <= ~berr;
    pw_tc <= ~tc;
    pw_size <= ~size;
    pw_addr <= ~addr;
    pw_data <= ~data;
  endtask
endmodule

// [tb/pwel_top_tb.sv]
/*
  Self-checking bench for the posted-write error log: register tasks on
  the plain strobe port, error events from the bus slave model.
  Assumes the register map and field layout of pwel_pkg.
*/
`timescale 1ns/1ps
module pwel_top_tb;
  logic ref_clk;
  logic rst_n;
  logic [pwel_pkg::ADDR_W-1:0] reg_addr;
  logic [pwel_pkg::DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [pwel_pkg::DATA_W-1:0] reg_rdata;
  logic pw_done;
  logic pw_berr;
  logic [pwel_pkg::TC_W-1:0] pw_tc;
  logic [pwel_pkg::SIZ_W-1:0] pw_size;
  logic [pwel_pkg::DATA_W-1:0] pw_addr;
  logic [pwel_pkg::DATA_W-1:0] pw_data;
  logic irq;
  int failures = 0;
  int compares = 0;
  localparam logic [pwel_pkg::ADDR_W-1:0] CSR = pwel_pkg::OFS_CTRL_STATUS;
  localparam logic [pwel_pkg::ADDR_W-1:0] ISR = pwel_pkg::OFS_INT_STATUS;
  localparam logic [pwel_pkg::ADDR_W-1:0] IMR = pwel_pkg::OFS_INT_MASK;

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  pwel_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pw_done(pw_done), .pw_berr(pw_berr),
    .pw_tc(pw_tc), .pw_size(pw_size), .pw_addr(pw_addr), .pw_data(pw_data), .irq(irq));
  pwel_bus_slave bus (.ref_clk(ref_clk), .pw_done(pw_done), .pw_berr(pw_berr), .pw_tc(pw_tc),
    .pw_size(pw_size), .pw_addr(pw_addr), .pw_data(pw_data));

  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      failures++;
    end
  endtask

  task automatic wr(input logic [pwel_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [pwel_pkg::ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, $sformatf("read of %h", a));
  endtask

  task automatic chk_irq(input logic exp);
    chk({31'h0, irq}, {31'h0, exp}, "interrupt line");
  endtask

  // Expected control and status word from its fields
  function automatic logic [31:0] cs(input logic en, input logic st, input logic [3:0] tc, input logic [1:0] sz);
    cs = (32'(en) << pwel_pkg::EN_BIT) | (32'(st) << pwel_pkg::STATUS_BIT) |
      (32'(tc) << pwel_pkg::TC_LSB) | (32'(sz) << pwel_pkg::SIZ_LSB);
  endfunction

  // Watchdog: a hung run still reaches the verdict
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    $display("mismatch at %0t: run did not finish", $time);
    failures++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [pwel_pkg::ADDR_W-1:0] ofs[5];
    ofs = '{pwel_pkg::OFS_CTRL_STATUS, pwel_pkg::OFS_ADDR_LOG, pwel_pkg::OFS_DATA_LOG, ISR, IMR};
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;

    // Every register clear after reset, line quiet
    foreach (ofs[i]) rd(ofs[i], pwel_pkg::RST_WORD);
    chk_irq(1'b0);
    $display("test reset done");

    // Logging off: a bus error leaves no trace
    bus.finish_write(1'b1, 4'h5, 2'h1, 32'h1111_2222, 32'h3333_4444);
    rd(CSR, 32'h0000_0000);
    rd(ISR, 32'h0000_0000);
    $display("test disabled done");

    // Logging on: clean write ignored, failed write captured whole
    wr(IMR, 32'h0000_0001);
    wr(CSR, cs(1, 0, 0, 0));
    bus.finish_write(1'b0, 4'h9, 2'h2, 32'h5555_6666, 32'h7777_8888);
    rd(CSR, cs(1, 0, 0, 0));
    // Read strobe lands on the edge right after the event edge
    fork
      bus.finish_write(1'b1, 4'ha, 2'h3, 32'h8000_1234, 32'hdead_beef);
      begin
        @(posedge ref_clk);
        rd(CSR, cs(1, 1, 4'ha, 2'h3));
      end
    join
    rd(pwel_pkg::OFS_ADDR_LOG, 32'h8000_1234);
    rd(pwel_pkg::OFS_DATA_LOG, 32'hdead_beef);
    rd(ISR, 32'h0000_0001);
    chk_irq(1'b1);
    $display("test capture done");

    // Two more errors while held, one idle cycle apart: record kept, miss flagged
    bus.finish_write(1'b1, 4'h3, 2'h0, 32'h0bad_0bad, 32'h0f0f_0f0f);
    bus.finish_write(1'b1, 4'h4, 2'h1, 32'h0cab_0cab, 32'h1e1e_1e1e);
    rd(CSR, cs(1, 1, 4'ha, 2'h3));
    rd(pwel_pkg::OFS_ADDR_LOG, 32'h8000_1234);
    rd(pwel_pkg::OFS_DATA_LOG, 32'hdead_beef);
    rd(ISR, 32'h0000_0003);
    $display("test held done");

    // Written zero leaves status alone; enable off gates the interrupt
    wr(CSR, cs(1, 0, 0, 0));
    rd(CSR, cs(1, 1, 4'ha, 2'h3));
    wr(CSR, cs(0, 0, 0, 0));
    chk_irq(1'b0);
    rd(CSR, cs(0, 1, 4'ha, 2'h3));
    wr(CSR, cs(1, 0, 0, 0));
    chk_irq(1'b1);
    wr(CSR, cs(1, 1, 0, 0));
    rd(CSR, cs(1, 0, 0, 0));
    rd(pwel_pkg::OFS_ADDR_LOG, 32'h0000_0000);
    rd(pwel_pkg::OFS_DATA_LOG, 32'hdead_beef);
    $display("test clear done");

    // Interrupt status cleared by ones, then masked path
    wr(ISR, 32'h0000_0003);
    rd(ISR, 32'h0000_0000);
    chk_irq(1'b0);
    wr(IMR, 32'h0000_0000);
    fork
      bus.finish_write(1'b1, 4'h6, 2'h2, 32'h4000_0010, 32'hcafe_f00d);
      begin
        @(posedge ref_clk);
        rd(pwel_pkg::OFS_ADDR_LOG, 32'h4000_0010);
      end
    join
    chk_irq(1'b0);
    wr(IMR, 32'h0000_0003);
    chk_irq(1'b1);
    rd(IMR, 32'h0000_0003);
    $display("test mask done");

    // Combined write: clear status and disable logging together
    wr(CSR, cs(0, 1, 0, 0));
    rd(CSR, 32'h0000_0000);
    chk_irq(1'b0);
    bus.finish_write(1'b1, 4'h7, 2'h1, 32'h2000_0020, 32'h1234_5678);
    rd(CSR, 32'h0000_0000);
    rd(ISR, 32'h0000_0001);
    $display("test combined done");

    // Unmapped places read zero and swallow writes
    wr(12'h000, 32'hffff_ffff);
    rd(12'h000, 32'h0000_0000);
    wr(12'hf94, 32'hffff_ffff);
    rd(12'hf94, 32'h0000_0000);
    rd(CSR, 32'h0000_0000);
    $display("test unmapped done");
    test_done();
  end
endmodule
